// *** jtap_map.vh ***
// Constants for the reduced test access port
`ifndef JTAP_MAP_VH
`define JTAP_MAP_VH
`define JTAP_IR_W 4
`define JTAP_ID_W 32
`define JTAP_IR_BYPASS 4'hF
`define JTAP_IR_IDCODE 4'h1
`define JTAP_IR_CAPTURE 4'h1
`define JTAP_ST_W 4
`define JTAP_TLR 4'hF
`define JTAP_RTI 4'hC
`define JTAP_SELDR 4'h7
`define JTAP_CAPDR 4'h6
`define JTAP_SHDR 4'h2
`define JTAP_EX1DR 4'h1
`define JTAP_PADR 4'h3
`define JTAP_EX2DR 4'h0
`define JTAP_UPDR 4'h5
`define JTAP_SELIR 4'h4
`define JTAP_CAPIR 4'hE
`define JTAP_SHIR 4'hA
`define JTAP_EX1IR 4'h9
`define JTAP_PAIR 4'hB
`define JTAP_EX2IR 4'h8
`define JTAP_UPIR 4'hD
`endif

// *** jtap_sync.v ***
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module jtap_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous level in
  input wire din,
  // Synchronised level and edges
  output wire dout,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Pins idle high on pull-ups; resetting low would fake an edge
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign dout = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule // jtap_sync

// *** jtap_fsm.v ***
// Sixteen-state test controller sequencer, stepped on test clock rises
`timescale 1ns/1ps
`include "jtap_map.vh"
module jtap_fsm (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Step enable and mode select
  input wire step,
  input wire tms,
  // Current state
  output reg [3:0] state_q
);
  reg [3:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      `JTAP_TLR: state_d = tms ? `JTAP_TLR : `JTAP_RTI;
      `JTAP_RTI: state_d = tms ? `JTAP_SELDR : `JTAP_RTI;
      `JTAP_SELDR: state_d = tms ? `JTAP_SELIR : `JTAP_CAPDR;
      `JTAP_CAPDR: state_d = tms ? `JTAP_EX1DR : `JTAP_SHDR;
      `JTAP_SHDR: state_d = tms ? `JTAP_EX1DR : `JTAP_SHDR;
      `JTAP_EX1DR: state_d = tms ? `JTAP_UPDR : `JTAP_PADR;
      `JTAP_PADR: state_d = tms ? `JTAP_EX2DR : `JTAP_PADR;
      `JTAP_EX2DR: state_d = tms ? `JTAP_UPDR : `JTAP_SHDR;
      `JTAP_UPDR: state_d = tms ? `JTAP_SELDR : `JTAP_RTI;
      `JTAP_SELIR: state_d = tms ? `JTAP_TLR : `JTAP_CAPIR;
      `JTAP_CAPIR: state_d = tms ? `JTAP_EX1IR : `JTAP_SHIR;
      `JTAP_SHIR: state_d = tms ? `JTAP_EX1IR : `JTAP_SHIR;
      `JTAP_EX1IR: state_d = tms ? `JTAP_UPIR : `JTAP_PAIR;
      `JTAP_PAIR: state_d = tms ? `JTAP_EX2IR : `JTAP_PAIR;
      `JTAP_EX2IR: state_d = tms ? `JTAP_UPIR : `JTAP_SHIR;
      `JTAP_UPIR: state_d = tms ? `JTAP_SELDR : `JTAP_RTI;
      default: state_d = `JTAP_TLR;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= `JTAP_TLR;
    end else if (step) begin
      state_q <= state_d;
    end
  end
endmodule // jtap_fsm

// *** jtap_tap.v ***
// Reduced boundary-scan test access port: bypass and identification only
`timescale 1ns/1ps
`include "jtap_map.vh"
module jtap_tap #(
  parameter [31:0] ID_VALUE = 32'h1234_5001, // Arbitrary identification
  parameter [0:0] PORT_EN_DEFAULT = 1'b1
) (
  // Clock and power-up reset
  input wire clk,
  input wire rst_n,
  // Configuration: port function enable from the loaded design
  input wire cfg_port_en,
  input wire cfg_valid,
  // Test port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_q,
  output reg tdo_oe_q,
  // General I/O use of the four pins when the port is disabled
  output reg gpio_mode_q,
  // Status toward the user logic
  output reg [3:0] ir_q,
  output reg [3:0] tap_state_q
);
  ////////////////////////////////////////////////////////////////////////
  wire tck_s;
  wire tck_rise;
  wire tck_fall;
  wire tms_s;
  wire tdi_s;
  wire [3:0] state;
  reg port_en_q;
  reg [3:0] irsh_q;
  reg byp_q;
  reg [31:0] idsh_q;
  reg out_bit;

  // Test clock edges are found by sampling; data pins pass two flops too
  jtap_sync u_tck (.clk(clk), .rst_n(rst_n), .din(tck), .dout(tck_s),
    .rise(tck_rise), .fall(tck_fall));
  jtap_sync u_tms (.clk(clk), .rst_n(rst_n), .din(tms), .dout(tms_s),
    .rise(), .fall());
  jtap_sync u_tdi (.clk(clk), .rst_n(rst_n), .din(tdi), .dout(tdi_s),
    .rise(), .fall());

  ////////////////////////////////////////////////////////////////////////
  // Port disabled: pins are left alone as general I/O, edges ignored
  jtap_fsm u_fsm (.clk(clk), .rst_n(rst_n),
    .step(tck_rise & port_en_q), .tms(tms_s), .state_q(state));

  // Reset loads PORT_EN_DEFAULT; a loaded configuration may turn it off or on
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_en_q <= PORT_EN_DEFAULT;
      gpio_mode_q <= ~PORT_EN_DEFAULT;
    end else if (cfg_valid) begin
      port_en_q <= cfg_port_en;
      gpio_mode_q <= ~cfg_port_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers shift on rising test clock edges only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Only power-up reset reaches here; no test-reset pin exists
      irsh_q <= `JTAP_IR_CAPTURE;
      ir_q <= `JTAP_IR_IDCODE;
      byp_q <= 1'b0;
      idsh_q <= 32'h0000_0000;
    end else if (tck_rise && port_en_q) begin
      case (state)
        `JTAP_TLR: ir_q <= `JTAP_IR_IDCODE;
        `JTAP_CAPIR: irsh_q <= `JTAP_IR_CAPTURE;
        `JTAP_SHIR: irsh_q <= {tdi_s, irsh_q[3:1]};
        `JTAP_UPIR: ir_q <= irsh_q;
        `JTAP_CAPDR: begin
          byp_q <= 1'b0;
          idsh_q <= ID_VALUE;
        end
        `JTAP_SHDR: begin
          if (ir_q == `JTAP_IR_IDCODE) begin
            idsh_q <= {tdi_s, idsh_q[31:1]};
          end else begin
            // Every other code acts as bypass, device logic untouched
            byp_q <= tdi_s;
          end
        end
        default: byp_q <= byp_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    if (state == `JTAP_SHIR) begin
      out_bit = irsh_q[0];
    end else if (ir_q == `JTAP_IR_IDCODE) begin
      out_bit = idsh_q[0];
    end else begin
      out_bit = byp_q;
    end
  end

  // Output and its enable move on falling edges, as the shift state stood; turning the port off drops the enable at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (!port_en_q || (cfg_valid && !cfg_port_en)) begin
      // Release the pin in the same cycle the pins turn general I/O
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_q <= (state == `JTAP_SHIR) || (state == `JTAP_SHDR);
      tdo_q <= out_bit;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_state_q <= `JTAP_TLR;
    end else begin
      tap_state_q <= state;
    end
  end
endmodule // jtap_tap

// *** jtap_tap_sva.sv ***
// Checker for the reduced test access port
`timescale 1ns/1ps
`include "jtap_map.vh"
module jtap_tap_sva #(
  parameter [31:0] ID_VALUE = 32'h1234_5001,
  parameter [0:0] PORT_EN_DEFAULT = 1'b1
) (
  input wire clk, rst_n, cfg_port_en, cfg_valid, tck, tms, tdi,
  input wire tdo_q, tdo_oe_q, gpio_mode_q,
  input wire [3:0] ir_q, tap_state_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire sh = tap_state_q == `JTAP_SHDR || tap_state_q == `JTAP_SHIR;
  ////////////////////////////////////////////////////////////////////
  a_oe_rise_shift: assert property ($rose(tdo_oe_q) |-> sh)
    else $error("output enabled outside a shift state");
  a_oe_follows: assert property ($fell(tck) ##1 sh && !gpio_mode_q
    |-> ##[0:4] tdo_oe_q)
    else $error("output not enabled while shifting");
  a_gpio_no_oe: assert property (gpio_mode_q |-> !tdo_oe_q)
    else $error("output enabled in general I/O mode");
  a_gpio_frozen: assert property (gpio_mode_q && $past(gpio_mode_q, 2)
    |-> $stable(tap_state_q)) else $error("state moved while off");
  a_cfg_off: assert property (cfg_valid && !cfg_port_en
    |-> ##[1:2] gpio_mode_q) else $error("port not disabled");
  a_tdo_on_fall: assert property (tdo_oe_q && $past(tdo_oe_q)
    && $changed(tdo_q) |-> !$past(tck, 3))
    else $error("serial output moved off a falling edge");
  a_step_on_rise: assert property ($changed(tap_state_q)
    |-> $past(tck, 3)) else $error("state moved off a rising edge");
  a_ir_update: assert property ($changed(ir_q) |-> ##[0:1]
    (tap_state_q == `JTAP_UPIR || tap_state_q == `JTAP_TLR))
    else $error("instruction changed outside update");
  a_tlr_idcode: assert property ($changed(tap_state_q) && tap_state_q
    == `JTAP_TLR |-> ##[0:3] ir_q == `JTAP_IR_IDCODE)
    else $error("logic reset left a wrong instruction");
endmodule // jtap_tap_sva
bind jtap_tap jtap_tap_sva #(.ID_VALUE(ID_VALUE),
  .PORT_EN_DEFAULT(PORT_EN_DEFAULT)) u_sva (.clk(clk), .rst_n(rst_n),
  .cfg_port_en(cfg_port_en), .cfg_valid(cfg_valid), .tck(tck),
  .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q),
  .gpio_mode_q(gpio_mode_q), .ir_q(ir_q), .tap_state_q(tap_state_q));

// *** jtap_ctl_model.sv ***
// Test controller model driving the serial test pins
`timescale 1ns/1ps
module jtap_ctl_model (
  input wire clk,
  output reg tck, tms, tdi,
  input wire tdo_q, tdo_oe_q
);
  // Pull-ups hold the idle pins high; the clock stands high between frames
  initial begin tck = 1'b1; tms = 1'b1; tdi = 1'b1; end
  task cyc(input m, input d, output o);
    begin
      @(negedge clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(negedge clk);
      tck <= 1'b1;
      repeat (4) @(negedge clk);
      o = tdo_oe_q ? tdo_q : 1'bz;
      tms <= 1'b1;
      tdi <= 1'b1;
    end
  endtask
endmodule // jtap_ctl_model

// *** jtap_tap_tb_top.sv ***
// Testbench for the reduced test access port
`timescale 1ns/1ps
`include "jtap_map.vh"
module jtap_tap_tb_top;
  localparam [31:0] ID = 32'hA5C3_0F01; // Arbitrary identification
  reg clk = 0, rst_n = 0, cfg_port_en = 1, cfg_valid = 0, o;
  wire tck, tms, tdi, tdo_q, tdo_oe_q, gpio_mode_q;
  wire [3:0] ir_q, tap_state_q;
  integer mismatches = 0, n_compared = 0, cycles = 0, k;
  reg [31:0] got;
  always #5 clk = ~clk;
  jtap_tap #(.ID_VALUE(ID), .PORT_EN_DEFAULT(1'b1)) DUT (.clk(clk),
    .rst_n(rst_n), .cfg_port_en(cfg_port_en), .cfg_valid(cfg_valid),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q),
    .gpio_mode_q(gpio_mode_q), .ir_q(ir_q), .tap_state_q(tap_state_q));
  jtap_ctl_model ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q));
  task chk(input [31:0] a, input [31:0] e, input [8*12:1] m);
    begin
      n_compared = n_compared + 1;
      if (a !== e) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t %0s", $time, m);
      end
    end
  endtask
  // Mode select walk, first step in bit 0
  task walk(input [7:0] s, input integer n);
    begin
      for (k = 0; k < n; k = k + 1) ctl.cyc(s[k], 1'b1, o);
      repeat (2) @(negedge clk);
    end
  endtask
  // Shift n bits, leaving the shift state on the last one
  task shift(input [31:0] d, input integer n);
    begin
      got = 0;
      for (k = 0; k < n; k = k + 1) ctl.cyc(k == n - 1, d[k], got[k]);
    end
  endtask
  task t_reset;
    begin
      chk(ir_q, `JTAP_IR_IDCODE, "reset ir");
      chk(tap_state_q, `JTAP_TLR, "reset state");
      chk({gpio_mode_q, tdo_oe_q}, 2'b00, "reset port");
    end
  endtask
  task t_idcode;
    begin
      walk(8'h1F, 5);
      chk(ir_q, `JTAP_IR_IDCODE, "tlr ir");
      walk(8'h02, 4);
      shift(32'h0, 32);
      chk(got, ID, "idcode");
      walk(8'h01, 2);
      chk(tdo_oe_q, 1'b0, "oe idle");
    end
  endtask
  task t_bypass;
    begin
      walk(8'h03, 4);
      shift(32'hF, 4);
      chk(got[3:0], `JTAP_IR_CAPTURE, "ir capture");
      walk(8'h01, 2);
      chk(ir_q, `JTAP_IR_BYPASS, "bypass ir");
      walk(8'h01, 3);
      shift(32'hB4, 8);
      chk(got[7:0], 8'h68, "bypass data");
      walk(8'h01, 2);
      chk(tap_state_q, `JTAP_RTI, "idle state");
    end
  endtask
  task t_disable;
    begin
      cfg_port_en = 1'b0;
      cfg_valid = 1'b1;
      @(negedge clk) cfg_valid = 1'b0;
      repeat (3) @(negedge clk);
      chk(gpio_mode_q, 1'b1, "gpio on");
      walk(8'h1F, 5);
      chk(tap_state_q, `JTAP_RTI, "ignored");
      cfg_port_en = 1'b1;
      cfg_valid = 1'b1;
      @(negedge clk) cfg_valid = 1'b0;
      repeat (3) @(negedge clk);
      chk(gpio_mode_q, 1'b0, "gpio off");
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Ceiling well above the 71 test clocks (about 680 clock cycles) the run needs
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    t_idcode;
    t_bypass;
    t_disable;
    end_sim;
  end
endmodule // jtap_tap_tb_top
